// >>> dcuo_host_model.sv
`timescale 1ns/100ps
// ==========
// Serial host
module dcuo_host_model (
   output logic serial_clk,
   output logic frame_sync_n,
   output logic serial_din
);
   initial begin
      serial_clk = 1'b1;
      frame_sync_n = 1'b1;
      serial_din = 1'b0;
   end
   task automatic send(input logic [31:0] w);
      // A frame lasts 4160 ns, a whole number of system clock periods.
      // Pin changes sit 1 ns off a 2.5 ns grid, so none lands on a system clock edge.
      #1;
      frame_sync_n = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         serial_clk = 1'b1;
         serial_din = w[i];
         #62.5;
         serial_clk = 1'b0;
         #62.5;
      end
      serial_clk = 1'b1;
      #62.5;
      frame_sync_n = 1'b1;
      // The released line toggles so a stale bit is never mistaken for data.
      serial_din = ~serial_din;
      #96.5;
   endtask
endmodule

// >>> dcuo_monitor.sv
`timescale 1ns/100ps
// ==========
// Checker
module dcuo_monitor (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic load_outputs_n,
   input wire logic async_clear_n,
   input dcuo_pkg::dcuo_code_t dac_value_a,
   input dcuo_pkg::dcuo_code_t dac_value_d,
   input wire logic [1:0] clear_value_select,
   input wire logic [3:0] channel_update_override,
   input wire logic clear_mode,
   input wire logic frame_done
);
   import dcuo_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   dcuo_code_t exp_code;
   always_comb begin
      exp_code = (clear_value_select == 2'h0) ? 16'h0000 :
         (clear_value_select == 2'h1) ? 16'h8000 : 16'hFFFF;
   end
   sequence s_clr_load;
      $rose(clear_mode) && clear_value_select != 2'h3;
   endsequence
   sequence s_pin_low;
      !$past(load_outputs_n, 3) || !$past(load_outputs_n, 4) || !$past(load_outputs_n, 5);
   endsequence
   property p_rst_regs;
      disable iff (1'b0) !nrst |=> clear_value_select == 2'h0 &&
         channel_update_override == 4'h0 && !clear_mode;
   endproperty
   property p_sel_frame;
      $changed(clear_value_select) |-> frame_done;
   endproperty
   property p_ovr_frame;
      $changed(channel_update_override) |-> frame_done;
   endproperty
   property p_clr_code;
      s_clr_load |-> dac_value_a == exp_code && dac_value_d == exp_code;
   endproperty
   property p_clr_edge;
      $fell(async_clear_n) |-> ##[1:8] clear_mode;
   endproperty
   property p_clr_exit;
      $fell(clear_mode) |-> frame_done || $past(frame_done);
   endproperty
   property p_done_pulse;
      frame_done |=> !frame_done [*8];
   endproperty
   property p_pin_gate;
      $changed(dac_value_a) && !channel_update_override[0] |-> $rose(clear_mode) or s_pin_low;
   endproperty
   a_rst_regs: assert property (p_rst_regs) else $error("reset values wrong");
   a_sel_frame: assert property (p_sel_frame) else $error("select moved alone");
   a_ovr_frame: assert property (p_ovr_frame) else $error("override moved alone");
   a_clr_code: assert property (p_clr_code) else $error("clear code wrong");
   a_clr_edge: assert property (p_clr_edge) else $error("clear edge lost");
   a_clr_exit: assert property (p_clr_exit) else $error("clear mode left early");
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   a_pin_gate: assert property (p_pin_gate) else $error("output moved ungated");
endmodule
bind dcuo_top dcuo_monitor i_mon (.sys_clk(sys_clk), .nrst(nrst),
   .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
   .dac_value_a(dac_value_a), .dac_value_d(dac_value_d),
   .clear_value_select(clear_value_select),
   .channel_update_override(channel_update_override),
   .clear_mode(clear_mode), .frame_done(frame_done));

// >>> dcuo_params.svh
`ifndef DCUO_PARAMS_SVH
`define DCUO_PARAMS_SVH
//======================================================================
//======================================================================
`define DCUO_FRAME_BITS 32
`define DCUO_CMD_HI 27
`define DCUO_CMD_LO 24
`define DCUO_ADDR_HI 23
`define DCUO_ADDR_LO 20
`define DCUO_DATA_HI 19
`define DCUO_DATA_LO 4
`define DCUO_CLRSEL_HI 1
`define DCUO_CLRSEL_LO 0
`define DCUO_OVR_HI 3
`define DCUO_OVR_LO 0
`define DCUO_CMD_WRITE_INPUT 4'h0
`define DCUO_CMD_CLEAR_CODE 4'h5
`define DCUO_CMD_OVERRIDE 4'h6
`define DCUO_ADDR_ALL 4'hF
`define DCUO_CLRSEL_ZERO 2'h0
`define DCUO_CLRSEL_MID 2'h1
`define DCUO_CLRSEL_FULL 2'h2
`define DCUO_CLRSEL_NOP 2'h3
`define DCUO_CODE_ZERO 16'h0000
`define DCUO_CODE_MID 16'h8000
`define DCUO_CODE_FULL 16'hFFFF
`define DCUO_RST_CLRSEL 2'h0
`define DCUO_RST_OVR 4'h0
`define DCUO_RST_CODE 16'h0000
`endif

// >>> dcuo_pin_sync.sv
`timescale 1ns/100ps
module dcuo_pin_sync #(
   parameter logic INIT = 1'b1
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic pin,
   output logic level,
   output logic fall
);
   import dcuo_pkg::*;

   logic s1_reg, s2_reg, s3_reg;
   logic level_reg, level_next;
   logic fall_reg, fall_next;

   // A change counts only once the second and third stages agree.
   always_comb begin
      level_next = level_reg;
      if (s2_reg == s3_reg) begin
         level_next = s2_reg;
      end
      fall_next = level_reg & ~level_next;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
         level_reg <= INIT;
         fall_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level_reg <= level_next;
         fall_reg <= fall_next;
      end
   end

   assign level = level_reg;
   assign fall = fall_reg;
endmodule

// >>> dcuo_pkg.sv
package dcuo_pkg;
   typedef logic [15:0] dcuo_code_t;
   typedef enum logic [1:0] {
      DCUO_IDLE,
      DCUO_SHIFT,
      DCUO_DONE
   } dcuo_frame_t;
endpackage

// >>> dcuo_top.sv
`timescale 1ns/100ps
`include "dcuo_params.svh"
module dcuo_top #(
   parameter int CHANNELS = 4
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic serial_clk,
   input wire logic frame_sync_n,
   input wire logic serial_din,
   input wire logic load_outputs_n,
   input wire logic async_clear_n,
   output dcuo_pkg::dcuo_code_t dac_value_a,
   output dcuo_pkg::dcuo_code_t dac_value_b,
   output dcuo_pkg::dcuo_code_t dac_value_c,
   output dcuo_pkg::dcuo_code_t dac_value_d,
   output logic [1:0] clear_value_select,
   output logic [3:0] channel_update_override,
   output logic clear_mode,
   output logic frame_done
);
   import dcuo_pkg::*;

   //===================================================================
   // Pin synchronisers
   //===================================================================
   logic sclk_level, sclk_fall;
   logic sync_level, din_level;
   logic load_level, clear_fall;

   dcuo_pin_sync #(.INIT(1'b1)) u_sclk (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(serial_clk),
      .level(sclk_level),
      .fall(sclk_fall)
   );
   dcuo_pin_sync #(.INIT(1'b1)) u_sync (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(frame_sync_n),
      .level(sync_level),
      .fall()
   );
   dcuo_pin_sync #(.INIT(1'b0)) u_din (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(serial_din),
      .level(din_level),
      .fall()
   );
   dcuo_pin_sync #(.INIT(1'b1)) u_load (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(load_outputs_n),
      .level(load_level),
      .fall()
   );
   // The clear pin is delayed like the serial pins, so the abort lines up with the frame.
   dcuo_pin_sync #(.INIT(1'b1)) u_clear (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pin(async_clear_n),
      .level(),
      .fall(clear_fall)
   );

   //===================================================================
   // Frame receiver
   //===================================================================
   dcuo_frame_t state_reg, state_next;
   logic [4:0] count_reg, count_next;
   logic [31:0] shift_reg, shift_next;
   logic complete;
   logic [31:0] word;
   logic [3:0] cmd;
   logic [3:0] addr;
   dcuo_code_t data;

   assign word = {shift_reg[30:0], din_level};
   assign cmd = word[`DCUO_CMD_HI:`DCUO_CMD_LO];
   assign addr = word[`DCUO_ADDR_HI:`DCUO_ADDR_LO];
   assign data = word[`DCUO_DATA_HI:`DCUO_DATA_LO];

   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      shift_next = shift_reg;
      complete = 1'b0;
      case (state_reg)
         DCUO_IDLE: begin
            count_next = 5'h00;
            if (!sync_level) begin
               state_next = DCUO_SHIFT;
            end
         end
         DCUO_SHIFT: begin
            if (sync_level) begin
               state_next = DCUO_IDLE;
            end else if (sclk_fall) begin
               shift_next = word;
               count_next = count_reg + 5'h01;
               // frame ends on 32nd falling edge
               if (count_reg == 5'(`DCUO_FRAME_BITS - 1)) begin
                  complete = 1'b1;
                  state_next = DCUO_DONE;
               end
            end
         end
         DCUO_DONE: begin
            if (sync_level) begin
               state_next = DCUO_IDLE;
            end
         end
         default: begin
            state_next = DCUO_IDLE;
         end
      endcase
      if (clear_fall) begin
         complete = 1'b0;
         state_next = DCUO_DONE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_reg <= DCUO_IDLE;
         count_reg <= 5'h00;
         shift_reg <= 32'h00000000;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         shift_reg <= shift_next;
      end
   end

   //===================================================================
   // Configuration and channel registers
   //===================================================================
   logic [1:0] clrsel_reg, clrsel_next;
   logic [3:0] ovr_reg, ovr_next;
   logic clear_mode_reg, clear_mode_next;
   logic done_reg;
   dcuo_code_t input_reg [CHANNELS];
   dcuo_code_t input_next [CHANNELS];
   dcuo_code_t dac_reg [CHANNELS];
   dcuo_code_t dac_next [CHANNELS];
   dcuo_code_t clear_code;
   logic clear_hit;
   logic write_hit;

   always_comb begin
      clrsel_next = clrsel_reg;
      ovr_next = ovr_reg;
      clear_mode_next = clear_mode_reg;
      clear_code = `DCUO_CODE_ZERO;
      clear_hit = 1'b0;
      write_hit = 1'b0;
      case (clrsel_reg)
         `DCUO_CLRSEL_ZERO: begin
            clear_code = `DCUO_CODE_ZERO;
            clear_hit = clear_fall;
         end
         `DCUO_CLRSEL_MID: begin
            clear_code = `DCUO_CODE_MID;
            clear_hit = clear_fall;
         end
         `DCUO_CLRSEL_FULL: begin
            clear_code = `DCUO_CODE_FULL;
            clear_hit = clear_fall;
         end
         default: begin
            clear_hit = 1'b0;
         end
      endcase
      if (complete) begin
         // next completed frame of any command ends clear mode
         clear_mode_next = 1'b0;
         case (cmd)
            `DCUO_CMD_CLEAR_CODE: begin
               clrsel_next = word[`DCUO_CLRSEL_HI:`DCUO_CLRSEL_LO];
            end
            `DCUO_CMD_OVERRIDE: begin
               ovr_next = word[`DCUO_OVR_HI:`DCUO_OVR_LO];
            end
            `DCUO_CMD_WRITE_INPUT: begin
               write_hit = 1'b1;
            end
            default: begin
               write_hit = 1'b0;
            end
         endcase
      end
      if (clear_fall) begin
         clear_mode_next = 1'b1;
      end
      for (int i = 0; i < CHANNELS; i++) begin
         input_next[i] = input_reg[i];
         dac_next[i] = dac_reg[i];
         if (write_hit && (addr == `DCUO_ADDR_ALL || addr == 4'(i))) begin
            input_next[i] = data;
         end
         // pin low moves input to output
         if (ovr_reg[i] || !load_level) begin
            dac_next[i] = input_next[i];
         end
         if (clear_hit) begin
            input_next[i] = clear_code;
            dac_next[i] = clear_code;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         clrsel_reg <= `DCUO_RST_CLRSEL;
         ovr_reg <= `DCUO_RST_OVR;
         clear_mode_reg <= 1'b0;
         done_reg <= 1'b0;
         for (int i = 0; i < CHANNELS; i++) begin
            input_reg[i] <= `DCUO_RST_CODE;
            dac_reg[i] <= `DCUO_RST_CODE;
         end
      end else begin
         clrsel_reg <= clrsel_next;
         ovr_reg <= ovr_next;
         clear_mode_reg <= clear_mode_next;
         done_reg <= complete;
         for (int i = 0; i < CHANNELS; i++) begin
            input_reg[i] <= input_next[i];
            dac_reg[i] <= dac_next[i];
         end
      end
   end

   assign dac_value_a = dac_reg[0];
   assign dac_value_b = dac_reg[1];
   assign dac_value_c = dac_reg[2];
   assign dac_value_d = dac_reg[3];
   assign clear_value_select = clrsel_reg;
   assign channel_update_override = ovr_reg;
   assign clear_mode = clear_mode_reg;
   assign frame_done = done_reg;
endmodule

// >>> dcuo_top_tb_top.sv
`timescale 1ns/100ps
module dcuo_top_tb_top;
   import dcuo_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic load_outputs_n = 1'b1;
   logic async_clear_n = 1'b1;
   logic serial_clk, frame_sync_n, serial_din, clear_mode, frame_done;
   dcuo_code_t dac_a, dac_b, dac_c, dac_d;
   logic [1:0] sel;
   logic [3:0] ovr;
   int num_errors = 0;
   int n_checks = 0;
   int n_done = 0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (frame_done === 1'b1) n_done <= n_done + 1;
   dcuo_host_model i_host (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
      .serial_din(serial_din));
   dcuo_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .serial_clk(serial_clk),
      .frame_sync_n(frame_sync_n), .serial_din(serial_din),
      .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
      .dac_value_a(dac_a), .dac_value_b(dac_b), .dac_value_c(dac_c),
      .dac_value_d(dac_d), .clear_value_select(sel), .channel_update_override(ovr),
      .clear_mode(clear_mode), .frame_done(frame_done));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [31:0] frm(logic [3:0] c, logic [3:0] a, logic [15:0] d,
      logic [3:0] lo);
      return {4'hA, c, a, d, lo};
   endfunction
   task automatic pulse_clear;
      @(negedge sys_clk) async_clear_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      async_clear_n = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask
   task automatic t_reset;
      chk(dac_a, 16'h0000);
      chk({14'h0, sel}, 16'h0000);
      chk({12'h0, ovr}, 16'h0000);
   endtask
   task automatic t_clear_codes;
      logic [1:0] s [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
      logic [15:0] code [4] = '{16'h8000, 16'h0000, 16'hFFFF, 16'hFFFF};
      for (int i = 0; i < 4; i++) begin
         i_host.send(frm(4'h5, 4'h5, 16'hA5C3, {2'h2, s[i]}));
         chk({14'h0, sel}, {14'h0, s[i]});
         chk({15'h0, clear_mode}, 16'h0000);
         pulse_clear();
         chk(dac_a, code[i]);
         chk(dac_d, code[i]);
         chk({15'h0, clear_mode}, 16'h0001);
      end
   endtask
   task automatic t_override;
      i_host.send(frm(4'h6, 4'h9, 16'h3C7E, 4'h5));
      chk({12'h0, ovr}, 16'h0005);
      i_host.send(frm(4'h0, 4'hF, 16'h1234, 4'h0));
      chk(dac_a, 16'h1234);
      chk(dac_c, 16'h1234);
      chk(dac_b, 16'hFFFF);
      chk(dac_d, 16'hFFFF);
      @(negedge sys_clk) load_outputs_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      load_outputs_n = 1'b1;
      chk(dac_b, 16'h1234);
   endtask
   task automatic t_abort;
      int d0;
      d0 = n_done;
      fork
         i_host.send(frm(4'h0, 4'hF, 16'h5555, 4'h0));
         begin
            #2000;
            pulse_clear();
         end
      join
      chk(dac_a, 16'h1234);
      chk(16'(n_done - d0), 16'h0000);
      i_host.send(frm(4'h6, 4'h0, 16'h0000, 4'h0));
      chk({12'h0, ovr}, 16'h0000);
      i_host.send(frm(4'h0, 4'h0, 16'h4B2D, 4'h0));
      chk(dac_a, 16'h1234);
      @(negedge sys_clk) load_outputs_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      load_outputs_n = 1'b1;
      chk(dac_a, 16'h4B2D);
      chk(dac_b, 16'h1234);
      chk(dac_d, 16'h1234);
   endtask
   initial begin
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (6) @(negedge sys_clk);
      t_reset();
      t_clear_codes();
      t_override();
      t_abort();
      end_sim();
   end
   initial begin
      #300000;
      num_errors++;
      end_sim();
   end
endmodule
